// *** inc/ecsc_pkg.sv ***
// ecsc_pkg: constants and types for the command/schedule control register bank
// assumes: one 32-bit command register, accessed by strobes on the controller clock
package ecsc_pkg;

   // bit positions inside the command register
   localparam int unsigned SOFT_RST_BIT = 7;
   localparam int unsigned BELL_BIT = 6;
   localparam int unsigned ASYNC_EN_BIT = 5;
   localparam int unsigned PERIODIC_EN_BIT = 4;
   localparam int unsigned LSIZE_LSB = 2;
   localparam int unsigned LSIZE_MSB = 3;

   // frame list size encodings
   localparam logic [1:0] LSIZE_1024 = 2'h0;
   localparam logic [1:0] LSIZE_512 = 2'h1;
   localparam logic [1:0] LSIZE_256 = 2'h2;
   localparam logic [1:0] LSIZE_RSVD = 2'h3;

   // reset values
   localparam logic ASYNC_EN_RST = 1'h0;
   localparam logic PERIODIC_EN_RST = 1'h0;
   localparam logic [1:0] LSIZE_RST = 2'h0;

   // widths
   localparam int unsigned FRAME_IDX_W = 14;
   localparam int unsigned LIST_IDX_W = 10;

   // command register fields held by the block
   typedef struct packed {
      logic soft_busy;
      logic bell;
      logic async_en;
      logic periodic_en;
      logic [1:0] lsize;
   } ecsc_cmd_t;

endpackage

// *** rtl/ecsc_frame_sel.sv ***
// ecsc_frame_sel: picks the frame list index out of the frame index counter
// assumes: frame index counter and size field on the same clock
`timescale 1ns/1ps
module ecsc_frame_sel (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [1:0] lsize,
   input wire logic [ecsc_pkg::FRAME_IDX_W-1:0] frame_index,
   output logic [ecsc_pkg::LIST_IDX_W-1:0] list_index_q
);

   // list index: bits from 3 upward, length by list size
   function automatic logic [ecsc_pkg::LIST_IDX_W-1:0] pick(
      input logic [1:0] size,
      input logic [ecsc_pkg::FRAME_IDX_W-1:0] fi);
      logic [ecsc_pkg::LIST_IDX_W-1:0] r;
      r = fi[12:3];
      case (size)
         ecsc_pkg::LSIZE_512: r = {1'h0, fi[11:3]};
         ecsc_pkg::LSIZE_256: r = {2'h0, fi[10:3]};
         default: r = fi[12:3];
      endcase
      return r;
   endfunction

   logic [ecsc_pkg::LIST_IDX_W-1:0] list_index_d;

   // next index
   always_comb begin
      list_index_d = pick(lsize, frame_index);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         list_index_q <= '0;
      end else begin
         list_index_q <= list_index_d;
      end
   end

   // the first edge after reset still shows the reset value, so skip it
   a_idx_follows: assert property (@(posedge clock) disable iff (!arst_n)
      $past(arst_n) |-> list_index_q == pick($past(lsize), $past(frame_index)))
      else $error("list index does not follow frame index and size");

endmodule

// *** rtl/ecsc_cmd_regs.sv ***
// ecsc_cmd_regs: command register bits for soft reset, doorbell, schedules, list size
// assumes: register strobes, status clear and engine events arrive on the same clock
`timescale 1ns/1ps
// Function
// - soft reset bit reads one while busy
// - soft reset bit reads zero once done
// - set advance status after cache eviction
// - interrupt at next threshold, when enabled
// - hardware clears doorbell after setting status
// - async enable resets zero, gates processing; here only driven out, nothing in this block is gated by it
// - periodic enable resets zero, gates processing; here only driven out, nothing in this block is gated by it
// - list size resets 00B, writable if flag
// - list size codes 1024, 512, 256
// - list size selects frame index bits
module ecsc_cmd_regs (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic programmable_list_flag,
   input wire logic soft_reset_done,
   input wire logic evict_done,
   input wire logic async_advance_irq_enable,
   input wire logic threshold_tick,
   input wire logic status_clear,
   input wire logic [ecsc_pkg::FRAME_IDX_W-1:0] frame_index,
   output logic [31:0] reg_rdata_q,
   output logic soft_reset_req_q,
   output logic async_advance_doorbell_q,
   output logic async_schedule_enable_q,
   output logic periodic_schedule_enable_q,
   output logic [1:0] frame_list_size_q,
   output logic async_advance_status_q,
   output logic status_set_q,
   output logic irq_q,
   output logic [ecsc_pkg::LIST_IDX_W-1:0] list_index_q
);

   ecsc_pkg::ecsc_cmd_t cmd_q;
   ecsc_pkg::ecsc_cmd_t cmd_d;
   logic soft_req_d;
   logic status_d;
   logic set_d;
   logic irq_d;
   logic [31:0] rdata_d;
   logic [1:0] lsize_wr;

   ////////////////////////////////////////////////////////////////////////////////
   // command fields
   always_comb begin
      cmd_d = cmd_q;
      soft_req_d = 1'h0;
      lsize_wr = reg_wdata[ecsc_pkg::LSIZE_MSB:ecsc_pkg::LSIZE_LSB];
      // soft reset: done clears busy, a new start only when idle
      if (soft_reset_done) begin
         cmd_d.soft_busy = 1'h0;
      end
      if (reg_wr && reg_wdata[ecsc_pkg::SOFT_RST_BIT] && !cmd_q.soft_busy) begin
         cmd_d.soft_busy = 1'h1;
         soft_req_d = 1'h1;
      end
      // doorbell drops the cycle after status is set; a new ring wins
      if (status_set_q) begin
         cmd_d.bell = 1'h0;
      end
      if (reg_wr && reg_wdata[ecsc_pkg::BELL_BIT]) begin
         cmd_d.bell = 1'h1;
      end
      if (reg_wr) begin
         cmd_d.async_en = reg_wdata[ecsc_pkg::ASYNC_EN_BIT];
         cmd_d.periodic_en = reg_wdata[ecsc_pkg::PERIODIC_EN_BIT];
         // size only writable with the flag; reserved code keeps old value
         if (programmable_list_flag && lsize_wr != ecsc_pkg::LSIZE_RSVD) begin
            cmd_d.lsize = lsize_wr;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= '{soft_busy: 1'h0, bell: 1'h0, async_en: ecsc_pkg::ASYNC_EN_RST,
                    periodic_en: ecsc_pkg::PERIODIC_EN_RST, lsize: ecsc_pkg::LSIZE_RST};
         soft_reset_req_q <= 1'h0;
      end else begin
         cmd_q <= cmd_d;
         soft_reset_req_q <= soft_req_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // advance status and its interrupt
   always_comb begin
      set_d = evict_done && cmd_q.bell && !status_set_q;
      status_d = set_d || (async_advance_status_q && !status_clear); // set wins
      if (irq_q) begin
         irq_d = status_d && async_advance_irq_enable;
      end else begin
         irq_d = threshold_tick && status_d && async_advance_irq_enable;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         async_advance_status_q <= 1'h0;
         status_set_q <= 1'h0;
         irq_q <= 1'h0;
      end else begin
         async_advance_status_q <= status_d;
         status_set_q <= set_d;
         irq_q <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, registered on the read strobe
   always_comb begin
      rdata_d = reg_rdata_q;
      if (reg_rd) begin
         rdata_d = 32'h0;
         rdata_d[ecsc_pkg::SOFT_RST_BIT] = cmd_q.soft_busy;
         rdata_d[ecsc_pkg::BELL_BIT] = cmd_q.bell;
         rdata_d[ecsc_pkg::ASYNC_EN_BIT] = cmd_q.async_en;
         rdata_d[ecsc_pkg::PERIODIC_EN_BIT] = cmd_q.periodic_en;
         rdata_d[ecsc_pkg::LSIZE_MSB:ecsc_pkg::LSIZE_LSB] = cmd_q.lsize;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 32'h0;
      end else begin
         reg_rdata_q <= rdata_d;
      end
   end

   // field outputs straight from the command flops
   assign async_advance_doorbell_q = cmd_q.bell;
   assign async_schedule_enable_q = cmd_q.async_en;
   assign periodic_schedule_enable_q = cmd_q.periodic_en;
   assign frame_list_size_q = cmd_q.lsize;

   ecsc_frame_sel u_frame_sel (
      .clock(clock),
      .arst_n(arst_n),
      .lsize(cmd_q.lsize),
      .frame_index(frame_index),
      .list_index_q(list_index_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_ring_evict;
      async_advance_doorbell_q && evict_done && !status_set_q;
   endsequence

   sequence s_set_then_drop;
      status_set_q ##0 async_advance_status_q ##1 !async_advance_doorbell_q;
   endsequence

   a_busy_reads_one: assert property (@(posedge clock) disable iff (!arst_n)
      reg_rd && cmd_q.soft_busy |=> reg_rdata_q[ecsc_pkg::SOFT_RST_BIT])
      else $error("soft reset bit read zero while busy");

   a_done_reads_zero: assert property (@(posedge clock) disable iff (!arst_n)
      soft_reset_done && !reg_wr ##1 reg_rd |=> !reg_rdata_q[ecsc_pkg::SOFT_RST_BIT])
      else $error("soft reset bit read one after done");

   a_evict_sets_status: assert property (@(posedge clock) disable iff (!arst_n)
      s_ring_evict |=> status_set_q && async_advance_status_q)
      else $error("advance status not set after eviction");

   a_bell_cleared: assert property (@(posedge clock) disable iff (!arst_n)
      s_ring_evict ##1 !(reg_wr && reg_wdata[ecsc_pkg::BELL_BIT]) |-> s_set_then_drop)
      else $error("doorbell not cleared after status set");

   a_irq_waits_tick: assert property (@(posedge clock) disable iff (!arst_n)
      !irq_q && !threshold_tick |=> !irq_q)
      else $error("interrupt rose without a threshold tick");

   a_irq_on_tick: assert property (@(posedge clock) disable iff (!arst_n)
      threshold_tick && async_advance_status_q && !status_clear
      && async_advance_irq_enable |=> irq_q)
      else $error("interrupt missing at threshold tick");

   a_enables_written: assert property (@(posedge clock) disable iff (!arst_n)
      reg_wr |=> async_schedule_enable_q == $past(reg_wdata[ecsc_pkg::ASYNC_EN_BIT])
      && periodic_schedule_enable_q == $past(reg_wdata[ecsc_pkg::PERIODIC_EN_BIT]))
      else $error("schedule enables do not take written value");

   a_lsize_locked: assert property (@(posedge clock) disable iff (!arst_n)
      !programmable_list_flag |=> $stable(frame_list_size_q))
      else $error("list size changed without programmable flag");

   a_lsize_no_rsvd: assert property (@(posedge clock) disable iff (!arst_n)
      frame_list_size_q != ecsc_pkg::LSIZE_RSVD)
      else $error("list size holds reserved code");

   a_lsize_write: assert property (@(posedge clock) disable iff (!arst_n)
      reg_wr && programmable_list_flag
      && reg_wdata[ecsc_pkg::LSIZE_MSB:ecsc_pkg::LSIZE_LSB] != ecsc_pkg::LSIZE_RSVD
      |=> frame_list_size_q == $past(reg_wdata[ecsc_pkg::LSIZE_MSB:ecsc_pkg::LSIZE_LSB]))
      else $error("list size did not take written code");

endmodule

// *** bench/test_ehci_command_schedule_ctrl.sv ***
// test_ehci_command_schedule_ctrl: self-checking bench for the command register bank
// assumes: ecsc_pkg compiled first, ecsc_cmd_regs is the top design module
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module test_ehci_command_schedule_ctrl;
   logic clock = 1'h0;
   logic arst_n = 1'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic programmable_list_flag = 1'h0;
   logic soft_reset_done = 1'h0;
   logic evict_done = 1'h0;
   logic async_advance_irq_enable = 1'h0;
   logic threshold_tick = 1'h0;
   logic status_clear = 1'h0;
   logic [ecsc_pkg::FRAME_IDX_W-1:0] frame_index = 14'h1a5b;
   logic [31:0] reg_rdata_q;
   logic soft_reset_req_q, async_advance_doorbell_q, async_schedule_enable_q;
   logic periodic_schedule_enable_q, async_advance_status_q, status_set_q, irq_q;
   logic [1:0] frame_list_size_q;
   logic [ecsc_pkg::LIST_IDX_W-1:0] list_index_q;
   logic [9:0] exp_idx;
   int mismatches = 0;
   int n_compared = 0;

   // 125 mhz controller clock
   always #4 clock = ~clock;

   ecsc_cmd_regs dut (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .programmable_list_flag(programmable_list_flag),
      .soft_reset_done(soft_reset_done), .evict_done(evict_done),
      .async_advance_irq_enable(async_advance_irq_enable), .threshold_tick(threshold_tick),
      .status_clear(status_clear), .frame_index(frame_index), .reg_rdata_q(reg_rdata_q),
      .soft_reset_req_q(soft_reset_req_q), .async_advance_doorbell_q(async_advance_doorbell_q),
      .async_schedule_enable_q(async_schedule_enable_q),
      .periodic_schedule_enable_q(periodic_schedule_enable_q),
      .frame_list_size_q(frame_list_size_q), .async_advance_status_q(async_advance_status_q),
      .status_set_q(status_set_q), .irq_q(irq_q), .list_index_q(list_index_q));

   ////////////////////////////////////////////////////////////////////////////////
   // helpers: comparison, clock step, register access
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic step;
      @(posedge clock);
      #1;
   endtask

   // one write strobe, fields settle at the taking edge
   task automatic wr(input logic [31:0] d);
      reg_wr = 1'h1;
      reg_wdata = d;
      step();
      reg_wr = 1'h0;
   endtask

   // one read strobe, data registered at the taking edge
   task automatic rd;
      reg_rd = 1'h1;
      step();
      reg_rd = 1'h0;
   endtask

   task automatic end_sim;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog against a hang
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      #1;
      arst_n = 1'h1;
      step();
      rd();
      `CHK(reg_rdata_q, 32'h0);
      `CHK({async_schedule_enable_q, periodic_schedule_enable_q}, 2'h0);
      `CHK(frame_list_size_q, ecsc_pkg::LSIZE_RST);
      // enables both ways, list size refused while flag low
      wr(32'h34);
      `CHK({async_schedule_enable_q, periodic_schedule_enable_q}, 2'h3);
      `CHK(frame_list_size_q, 2'h0);
      rd();
      `CHK(reg_rdata_q, 32'h30);
      wr(32'h0);
      `CHK({async_schedule_enable_q, periodic_schedule_enable_q}, 2'h0);
      // each valid size code and the index bits it selects
      programmable_list_flag = 1'h1;
      for (int c = 0; c < 3; c++) begin
         // a new counter value each pass, bits 12 and 11 kept high
         frame_index = 14'h1a5b ^ 14'(c * 32'h111);
         wr({26'h0, c[1:0], 2'h0});
         step();
         `CHK(frame_list_size_q, c[1:0]);
         exp_idx = (c == 0) ? frame_index[12:3] :
                   (c == 1) ? {1'h0, frame_index[11:3]} : {2'h0, frame_index[10:3]};
         `CHK(list_index_q, exp_idx);
         `CHK(list_index_q, exp_idx);
      end
      // reserved code keeps the old size
      wr(32'hc);
      `CHK(frame_list_size_q, ecsc_pkg::LSIZE_256);
      step();
      // light reset busy, then done; a second start while busy is ignored
      wr(32'h80);
      `CHK(soft_reset_req_q, 1'h1);
      rd();
      `CHK(reg_rdata_q[7], 1'h1);
      wr(32'h80);
      `CHK(soft_reset_req_q, 1'h0);
      soft_reset_done = 1'h1;
      step();
      soft_reset_done = 1'h0;
      step();
      rd();
      `CHK(reg_rdata_q[7], 1'h0);
      // doorbell with async schedule on
      async_advance_irq_enable = 1'h1;
      wr(32'h60);
      `CHK(async_advance_doorbell_q, 1'h1);
      `CHK(async_advance_status_q, 1'h0);
      evict_done = 1'h1;
      step();
      evict_done = 1'h0;
      `CHK({status_set_q, async_advance_status_q}, 2'h3);
      step();
      `CHK(async_advance_doorbell_q, 1'h0);
      `CHK(irq_q, 1'h0);
      step();
      `CHK(irq_q, 1'h0);
      threshold_tick = 1'h1;
      step();
      threshold_tick = 1'h0;
      `CHK(irq_q, 1'h1);
      status_clear = 1'h1;
      step();
      status_clear = 1'h0;
      step();
      `CHK({async_advance_status_q, irq_q}, 2'h0);
      end_sim();
   end
endmodule
